// File: core/uhftx_pkg.sv
// uhftx_pkg: constants and carrier types for the uhf transmitter control block
// assumes a single 200 MHz clock standing in for the crystal reference
//
// Contract
// - clock output runs at one eighth of the crystal reference rate.
// - clock output held low in power-down and after enabling until start-up done.
// - clock output released when the amplitude threshold event arrives.
// - release aligned to divided clock so the first period is complete.
// - high amplitude line turns amplifier on; with enable high/open powers synthesizer.
// - high shift line opens switch; low closes; with enable high/open powers up.
// - enable low with amplitude or shift high keeps device idle, all off.
// - synthesizer lock within 250 us after clock output activation.
// - nominal oscillator start-up delay of 0.6 ms from enabling.
// - controlled oscillator locks to 24 or 32 times the crystal frequency.
// - all lines low, enable low or open: power-down, clock output inactive.
// - enable open: power-up is the OR of amplitude and shift lines.
package uhftx_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned OSC_STARTUP_NS  = 600000;
  localparam int unsigned PLL_LOCK_NS     = 250000;
  localparam int unsigned OSC_STARTUP_CYC = OSC_STARTUP_NS * 1000 / CLK_PERIOD_PS;
  // lock flag trails its timer by one cycle: two off keeps the total under the limit
  localparam int unsigned PLL_LOCK_CYC    = PLL_LOCK_NS * 1000 / CLK_PERIOD_PS - 2;
  localparam int unsigned CLK_DIV         = 8;
  localparam int unsigned DIV_W           = 3;
  localparam int unsigned LOW_BAND_MULT   = 24;
  localparam int unsigned HIGH_BAND_MULT  = 32;
  localparam int unsigned TMR_W           = 20;
  localparam logic [TMR_W-1:0] TMR_RST    = 20'h0_0000;
  localparam logic [DIV_W-1:0] DIV_RST    = 3'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UHFTX_PDOWN   = 2'b00,
    UHFTX_STARTUP = 2'b01,
    UHFTX_LOCKING = 2'b11,
    UHFTX_READY   = 2'b10
  } uhftx_state_t;

  typedef struct packed {
    logic amplitude_drive;
    logic shift_drive;
    logic enable_drive;
    logic enable_drive_oe;
  } uhftx_ctrl_t;

  typedef struct packed {
    logic amplifier_on;
    logic shift_switch_open;
    logic synth_powered;
    logic idle;
    logic clock_out;
    logic clock_active;
    logic locked;
  } uhftx_stat_t;

endpackage : uhftx_pkg

// File: core/uhftx_timer.sv
// uhftx_timer: restartable cycle-count timer with a done level
// assumes run falls whenever the counted interval must restart
module uhftx_timer #(
  parameter int unsigned                 WIDTH = uhftx_pkg::TMR_W,
  parameter logic [uhftx_pkg::TMR_W-1:0] COUNT = (uhftx_pkg::TMR_W)'(1)
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  output logic      done_o
);

  if (WIDTH != uhftx_pkg::TMR_W || COUNT == '0)
  begin : g_bad_param
    $error("uhftx_timer: unsupported width or zero count");
  end

  typedef struct packed {
    logic [uhftx_pkg::TMR_W-1:0] cnt;
    logic                        done;
  } uhftx_tmr_st_t;

  uhftx_tmr_st_t st_q;
  uhftx_tmr_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (!run_i)
    begin
      st_d.cnt  = uhftx_pkg::TMR_RST;
      st_d.done = 1'b0;
    end
    else if (!st_q.done)
    begin
      st_d.cnt  = st_q.cnt + 1'b1;
      st_d.done = (st_d.cnt >= COUNT);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign done_o = st_q.done;

endmodule : uhftx_timer

// File: core/uhftx_ctrl.sv
// uhftx_ctrl: mode decode, amplifier gating, divided clock release and lock model
// assumes control lines synchronous to clk_i, which stands for the crystal
module uhftx_ctrl #(
  parameter logic [uhftx_pkg::TMR_W-1:0] STARTUP_CYC =
    (uhftx_pkg::TMR_W)'(uhftx_pkg::OSC_STARTUP_CYC),
  parameter logic [uhftx_pkg::TMR_W-1:0] LOCK_CYC    =
    (uhftx_pkg::TMR_W)'(uhftx_pkg::PLL_LOCK_CYC),
  parameter bit                          HIGH_BAND   = 1'b0,
  parameter bit                          USE_EXT_AMP = 1'b1
) (
  input  wire logic                 clk_i,
  input  wire logic                 rstn_i,
  input  wire uhftx_pkg::uhftx_ctrl_t ctrl_i,
  input  wire logic                 amp_threshold_i,
  output logic                      clock_o,
  output logic                      amplifier_on_o,
  output logic                      shift_switch_open_o,
  output logic                      synth_powered_o,
  output logic                      idle_o,
  output logic                      locked_o,
  output logic [5:0]                osc_mult_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    uhftx_pkg::uhftx_state_t   fsm;
    logic [uhftx_pkg::DIV_W-1:0] div;
    logic                      clk_out;
    logic                      amp;
    logic                      sw_open;
    logic                      synth;
    logic                      idle;
    logic                      locked;
    logic [5:0]                mult;
  } uhftx_ctrl_st_t;

  uhftx_ctrl_st_t st_q;
  uhftx_ctrl_st_t st_d;

  logic enable_high;
  logic any_line;
  logic power_up;
  logic start_done;
  logic lock_done;
  logic div_wrap;

  // open enable floats high: only an actively driven low disables
  assign enable_high = !ctrl_i.enable_drive_oe || ctrl_i.enable_drive;
  assign any_line    = ctrl_i.amplitude_drive || ctrl_i.shift_drive;
  assign power_up    = any_line && enable_high;
  assign div_wrap    = (st_q.div == (uhftx_pkg::DIV_W)'(uhftx_pkg::CLK_DIV - 1));

  // ----------------------------------------------------------------
  // analog event timers
  // ----------------------------------------------------------------
  uhftx_timer #(
    .WIDTH (uhftx_pkg::TMR_W),
    .COUNT (STARTUP_CYC)
  ) u_start (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (power_up),
    .done_o (start_done)
  );

  uhftx_timer #(
    .WIDTH (uhftx_pkg::TMR_W),
    .COUNT (LOCK_CYC)
  ) u_lock (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .run_i  (power_up && ((st_q.fsm == uhftx_pkg::UHFTX_LOCKING)
                          || (st_q.fsm == uhftx_pkg::UHFTX_READY))),
    .done_o (lock_done)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_d         = st_q;
    st_d.amp     = power_up && ctrl_i.amplitude_drive;
    st_d.sw_open = ctrl_i.shift_drive;
    st_d.synth   = power_up;
    st_d.idle    = any_line && !enable_high;
    st_d.mult    = HIGH_BAND ? 6'(uhftx_pkg::HIGH_BAND_MULT)
                             : 6'(uhftx_pkg::LOW_BAND_MULT);
    st_d.div     = power_up ? st_q.div + 1'b1 : uhftx_pkg::DIV_RST;
    case (st_q.fsm)
      uhftx_pkg::UHFTX_PDOWN:
      begin
        st_d.clk_out = 1'b0;
        st_d.locked  = 1'b0;
        if (power_up)
          st_d.fsm = uhftx_pkg::UHFTX_STARTUP;
      end
      uhftx_pkg::UHFTX_STARTUP:
      begin
        st_d.clk_out = 1'b0;
        // release only at a divider wrap so a full period follows
        if (!power_up)
          st_d.fsm = uhftx_pkg::UHFTX_PDOWN;
        else if ((USE_EXT_AMP ? amp_threshold_i : start_done) && div_wrap)
        begin
          // high phase starts on the wrap itself, else the first period is short
          st_d.fsm     = uhftx_pkg::UHFTX_LOCKING;
          st_d.clk_out = 1'b1;
        end
      end
      uhftx_pkg::UHFTX_LOCKING,
      uhftx_pkg::UHFTX_READY:
      begin
        st_d.clk_out = (st_d.div < (uhftx_pkg::DIV_W)'(uhftx_pkg::CLK_DIV / 2));
        st_d.locked  = lock_done;
        if (!power_up)
        begin
          st_d.fsm     = uhftx_pkg::UHFTX_PDOWN;
          st_d.clk_out = 1'b0;
          st_d.locked  = 1'b0;
        end
        else if (lock_done)
          st_d.fsm = uhftx_pkg::UHFTX_READY;
      end
      default:
      begin
        st_d.fsm     = uhftx_pkg::UHFTX_PDOWN;
        st_d.clk_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      st_q <= '{fsm: uhftx_pkg::UHFTX_PDOWN, div: uhftx_pkg::DIV_RST, default: '0};
    else
      st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign clock_o             = st_q.clk_out;
  assign amplifier_on_o      = st_q.amp;
  assign shift_switch_open_o = st_q.sw_open;
  assign synth_powered_o     = st_q.synth;
  assign idle_o              = st_q.idle;
  assign locked_o            = st_q.locked;
  assign osc_mult_o          = st_q.mult;

endmodule : uhftx_ctrl

// File: verif/uhftx_ctrl_props.sv
// uhftx_ctrl_chk: port properties of the control block
// assumes binding to uhftx_ctrl
module uhftx_ctrl_chk #(
  parameter logic [uhftx_pkg::TMR_W-1:0] LOCK_CYC  = 20'h0_0001,
  parameter bit                          HIGH_BAND = 1'b0
) (
  input wire logic                   clk_i,
  input wire logic                   rstn_i,
  input wire uhftx_pkg::uhftx_ctrl_t ctrl_i,
  input wire logic                   amp_threshold_i,
  input wire logic                   clock_o,
  input wire logic                   amplifier_on_o,
  input wire logic                   shift_switch_open_o,
  input wire logic                   synth_powered_o,
  input wire logic                   idle_o,
  input wire logic                   locked_o,
  input wire logic [5:0]             osc_mult_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        any, on, idl, seen_q;
  int unsigned since_q;
  assign any = ctrl_i.amplitude_drive | ctrl_i.shift_drive;
  assign on  = any & (~ctrl_i.enable_drive_oe | ctrl_i.enable_drive);
  assign idl = any & ctrl_i.enable_drive_oe & ~ctrl_i.enable_drive;
  // cycles since the clock output first rose in this power-up
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
    begin
      seen_q  <= 1'b0;
      since_q <= 0;
    end
    else
    begin
      seen_q  <= on & (seen_q | clock_o);
      since_q <= (on & (seen_q | clock_o)) ? since_q + 1 : 0;
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  chk_synth_power: assert property (1'b1 |=> synth_powered_o == $past(on))
    else $error("synth power");
  chk_idle_mode: assert property (idl |=> idle_o && !synth_powered_o && !clock_o)
    else $error("idle mode");
  chk_amp_gate: assert property (1'b1 |=> amplifier_on_o == $past(on & ctrl_i.amplitude_drive))
    else $error("amplifier");
  chk_shift_sw: assert property (1'b1 |=> shift_switch_open_o == $past(ctrl_i.shift_drive))
    else $error("shift switch");
  chk_pdown_quiet: assert property (!on |=> !clock_o && !locked_o)
    else $error("power-down");
  chk_clk_release: assert property ($rose(clock_o) && !$past(clock_o, 5) |-> $past(on) && $past(amp_threshold_i))
    else $error("release");
  chk_full_high: assert property ($rose(clock_o) ##0 on[*4]
    |=> !clock_o && $past(clock_o) && $past(clock_o, 2) && $past(clock_o, 3))
    else $error("high phase");
  chk_full_low: assert property ($fell(clock_o) && $past(on) ##0 on[*4] |=> clock_o)
    else $error("low phase");
  chk_lock_time: assert property ($rose(locked_o) |-> seen_q && since_q == LOCK_CYC + 1)
    else $error("lock time");
  chk_lock_late: assert property (seen_q && !locked_o |-> since_q <= LOCK_CYC + 1)
    else $error("lock late");
  chk_osc_mult: assert property (1'b1 |=> osc_mult_o == (HIGH_BAND ? 6'h20 : 6'h18))
    else $error("multiplier");
  cov_clock: cover property ($rose(clock_o));
  cov_lock: cover property ($rose(locked_o));
  cov_idle: cover property (idle_o);
endmodule : uhftx_ctrl_chk

bind uhftx_ctrl uhftx_ctrl_chk #(.LOCK_CYC(LOCK_CYC), .HIGH_BAND(HIGH_BAND)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .ctrl_i(ctrl_i), .amp_threshold_i(amp_threshold_i),
  .clock_o(clock_o), .amplifier_on_o(amplifier_on_o), .idle_o(idle_o),
  .shift_switch_open_o(shift_switch_open_o), .synth_powered_o(synth_powered_o),
  .locked_o(locked_o), .osc_mult_o(osc_mult_o));

// File: verif/uhftx_host.sv
// uhftx_host: host controller and crystal model
// assumes the bench asks for power, data and enable by level
module uhftx_host #(
  parameter int START = 20,
  parameter int WAIT  = 30
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              on_i,
  input  wire logic              ask_i,
  input  wire logic              float_i,
  input  wire logic              en_low_i,
  input  wire logic              clock_i,
  output uhftx_pkg::uhftx_ctrl_t ctrl_o,
  output logic                   thr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   osc_q, wait_q;
  logic seen_q;
  always_ff @(posedge clk_i or negedge rstn_i)
    if (!rstn_i)
      {osc_q, wait_q, seen_q} <= '0;
    else
    begin
      osc_q  <= on_i ? osc_q + int'(osc_q < START) : 0;
      seen_q <= on_i & (seen_q | clock_i);
      wait_q <= seen_q ? wait_q + int'(wait_q < WAIT) : 0;
    end
  assign thr_o                  = on_i && osc_q == START;
  assign ctrl_o.shift_drive     = on_i;
  // amplifier held off until the lock wait has run
  assign ctrl_o.amplitude_drive = ask_i && wait_q == WAIT;
  assign ctrl_o.enable_drive_oe = !float_i;
  // released line: no stable level to rely on
  assign ctrl_o.enable_drive    = float_i ? osc_q[0] : !en_low_i;
endmodule : uhftx_host

// File: verif/test_uhftx_ctrl.sv
// test_uhftx_ctrl: self-checking bench of the control block
// assumes the host model drives every control line
module test_uhftx_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
  logic clk_i, rstn_i, on, ask, flt, enl, thr, clk_o, amp_o, sw_o, syn_o, idl_o, lck_o;
  logic [5:0] mult, hb_mult;
  logic hb_clk;
  uhftx_pkg::uhftx_ctrl_t ctrl;
  int n_mismatch = 0, compares = 0, cyc = 0;
  uhftx_ctrl #(.STARTUP_CYC(20'h0_0014), .LOCK_CYC(20'h0_001e)) dut (.clk_i(clk_i),
    .rstn_i(rstn_i), .ctrl_i(ctrl), .amp_threshold_i(thr), .clock_o(clk_o),
    .amplifier_on_o(amp_o), .shift_switch_open_o(sw_o), .synth_powered_o(syn_o),
    .idle_o(idl_o), .locked_o(lck_o), .osc_mult_o(mult));
  // threshold held high: this copy must still wait for its own start-up timer
  uhftx_ctrl #(.STARTUP_CYC(20'h0_0014), .LOCK_CYC(20'h0_001e), .HIGH_BAND(1'b1),
    .USE_EXT_AMP(1'b0)) dut_hb (.clk_i(clk_i), .rstn_i(rstn_i), .ctrl_i(ctrl),
    .amp_threshold_i(1'b1), .clock_o(hb_clk), .amplifier_on_o(), .shift_switch_open_o(),
    .synth_powered_o(), .idle_o(), .locked_o(), .osc_mult_o(hb_mult));
  uhftx_host #(.START(20), .WAIT(30)) u_host (.clk_i(clk_i), .rstn_i(rstn_i), .on_i(on),
    .ask_i(ask), .float_i(flt), .en_low_i(enl), .clock_i(clk_o), .ctrl_o(ctrl), .thr_o(thr));
  initial
  begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_mismatch++;
      results();
    end
  end
  task step(input int n); repeat (n) @(posedge clk_i); #1; endtask : step
  task samp(output logic b); b = clk_o; step(1); endtask : samp
  task results;
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  task t_pdown;
    step(4);
    `CHK("idle", 1'b0, idl_o)
    `CHK("clock", 1'b0, clk_o)
    `CHK("mult", 6'h18, mult)
    `CHK("mult high", 6'h20, hb_mult)
  endtask : t_pdown
  task t_idle;
    on = 1; enl = 1; flt = 0; step(60);
    `CHK("idle", 1'b1, idl_o)
    `CHK("synth", 1'b0, syn_o)
    on = 0; enl = 0; step(2);
    `CHK("idle off", 1'b0, idl_o)
  endtask : t_idle
  task t_tx(input logic f);
    int k;
    logic [7:0] pat;
    logic early;
    flt = f; on = 1; early = 1'b0;
    for (k = 0; clk_o !== 1'b1 && k < 200; k++)
    begin
      early |= hb_clk;
      step(1);
    end
    `CHK("start delay", 1'b1, k >= 20 && k < 200)
    `CHK("timer release", 2'b01, {early, hb_clk})
    for (int i = 7; i >= 0; i--) samp(pat[i]);
    `CHK("clock shape", 8'hf0, pat)
    for (k = 8; lck_o !== 1'b1 && k < 200; k++) step(1);
    `CHK("lock time", 1'b1, k >= 28 && k <= 33)
    ask = 1; step(4);
    `CHK("amplifier", 1'b1, amp_o)
    `CHK("switch", 1'b1, sw_o)
    `CHK("synth", 1'b1, syn_o)
    on = 0; ask = 0; step(2);
    `CHK("clock off", 1'b0, clk_o)
    `CHK("lock off", 1'b0, lck_o)
    `CHK("switch", 1'b0, sw_o)
  endtask : t_tx
  initial
  begin
    rstn_i = 0; on = 0; ask = 0; flt = 1; enl = 0;
    step(8);
    rstn_i = 1;
    t_pdown();
    t_idle();
    t_tx(1'b1);
    t_tx(1'b0);
    results();
  end
endmodule : test_uhftx_ctrl
